// *** logic/vib_consts.vh ***
// register offsets, field positions and reset values for the bus and port core
// assumes inclusion by bare name from the design file
`ifndef VIB_CONSTS_VH
`define VIB_CONSTS_VH
`define VIB_REG_PORT_B_DATA 4'h0
`define VIB_REG_PORT_A_DATA 4'h1
`define VIB_REG_PORT_B_DIR 4'h2
`define VIB_REG_PORT_A_DIR 4'h3
`define VIB_REG_T1_COUNT_LOW 4'h4
`define VIB_REG_T1_COUNT_HIGH 4'h5
`define VIB_REG_T1_RELOAD_LOW 4'h6
`define VIB_REG_T1_RELOAD_HIGH 4'h7
`define VIB_REG_T2_COUNT_LOW 4'h8
`define VIB_REG_T2_COUNT_HIGH 4'h9
`define VIB_REG_SHIFTER 4'hA
`define VIB_REG_AUX_SETUP 4'hB
`define VIB_REG_CTRL_SETUP 4'hC
`define VIB_REG_INT_FLAGS 4'hD
`define VIB_REG_INT_ENABLES 4'hE
`define VIB_REG_PORT_A_QUIET 4'hF
`define VIB_RESET_BYTE 8'h00
// auxiliary setup: input latch enables
`define VIB_AUX_LATCH_A 0
`define VIB_AUX_LATCH_B 1
// control line setup: active edge selects (1 = rising)
`define VIB_CTL_CA1_EDGE 0
`define VIB_CTL_CB1_EDGE 4
// interrupt flag bit positions
`define VIB_IFL_CA2 0
`define VIB_IFL_CA1 1
`define VIB_IFL_CB2 3
`define VIB_IFL_CB1 4
`define VIB_IFL_ANY 7
// enable register write: bit 7 set = set bits, clear = clear bits
`define VIB_IEN_SETCLR 7
`endif

// *** logic/vib_bus_ports.v ***
// host bus slave, port A/B data and direction, control line flags and interrupt request
// assumes the host phase-2 clock, selects and strobes arrive asynchronously on pins
`timescale 1ns/1ns
`include "vib_consts.vh"

module vib_sync3 #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire srst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stageOne;
  reg [WIDTH-1:0] stageTwo;
  reg [WIDTH-1:0] stageThree;
  integer i;
  always @(posedge clock) begin
    if (srst) begin
      stageOne <= {WIDTH{1'b0}};
      stageTwo <= {WIDTH{1'b0}};
      stageThree <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      stageOne <= din;
      stageTwo <= stageOne;
      stageThree <= stageTwo;
      // a bit changes only once the second and third stages agree
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stageTwo[i] == stageThree[i]) begin
          dout[i] <= stageThree[i];
        end
      end
    end
  end
endmodule

module vib_bus_ports (
  input wire clock,
  input wire srst,
  input wire phaseTwo,
  input wire selectActiveHigh,
  input wire selectActiveLow_n,
  input wire [3:0] registerIndex,
  input wire readNotWrite,
  input wire [7:0] hostDataIn,
  output reg [7:0] hostDataOut,
  output reg hostDataOe,
  input wire [7:0] portALinesIn,
  output reg [7:0] portALinesOut,
  output reg [7:0] portALinesOe,
  input wire [7:0] portBLinesIn,
  output reg [7:0] portBLinesOut,
  output reg [7:0] portBLinesOe,
  input wire portACtrlFirst,
  input wire portACtrlSecondIn,
  output reg portACtrlSecondOut,
  output reg portACtrlSecondOe,
  input wire portBCtrlFirstIn,
  output reg portBCtrlFirstOut,
  output reg portBCtrlFirstOe,
  input wire portBCtrlSecondIn,
  output reg portBCtrlSecondOut,
  output reg portBCtrlSecondOe,
  input wire timerOneOutput,
  input wire timerOneDrivesPin,
  output reg pulseCountLevel,
  output reg serialClockLevel,
  output reg serialDataLevel,
  output reg [7:0] timerStorageWrData,
  output reg [3:0] timerStorageWrIndex,
  output reg timerStorageWrStrobe,
  input wire [7:0] timerStorageRdData,
  output reg interruptRequestOut,
  output reg interruptRequestOe
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [7:0] portAPin;
  wire [7:0] portBPin;
  wire [3:0] ctrlPin;
  wire [15:0] busPin;
  vib_sync3 #(.WIDTH(8)) syncPortA (
    .clock(clock),
    .srst(srst),
    .din(portALinesIn),
    .dout(portAPin)
  );
  vib_sync3 #(.WIDTH(8)) syncPortB (
    .clock(clock),
    .srst(srst),
    .din(portBLinesIn),
    .dout(portBPin)
  );
  vib_sync3 #(.WIDTH(4)) syncCtrl (
    .clock(clock),
    .srst(srst),
    .din({portBCtrlSecondIn, portBCtrlFirstIn, portACtrlSecondIn, portACtrlFirst}),
    .dout(ctrlPin)
  );
  // index and data cross bit by bit: the host must hold them steady before the
  // phase-2 rise, which then reaches the core no earlier than they do
  vib_sync3 #(.WIDTH(16)) syncBus (
    .clock(clock),
    .srst(srst),
    .din({phaseTwo, selectActiveHigh, selectActiveLow_n, registerIndex, readNotWrite, hostDataIn}),
    .dout(busPin)
  );
  wire phiLevel = busPin[15];
  wire selected = busPin[14] & ~busPin[13];
  wire [3:0] regIndex = busPin[12:9];
  wire readCycle = busPin[8];
  wire [7:0] writeData = busPin[7:0];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] portBOutLatch;
  reg [7:0] portAOutLatch;
  reg [7:0] portBDirection;
  reg [7:0] portADirection;
  reg [7:0] auxSetup;
  reg [7:0] ctrlSetup;
  reg [6:0] intFlags;
  reg [6:0] intEnables;
  reg [7:0] portAInLatch;
  reg [7:0] portBInLatch;
  reg portAHeld;
  reg portBHeld;
  reg phiLast;
  reg [3:0] ctrlLast;
  reg cycleOpen;
  reg cycleRead;
  reg [3:0] cycleIndex;
  reg [7:0] cycleData;
  reg [7:0] readMux;
  reg [2:0] settleCount;

  // the synchronisers restart from zero, so a line idling high would look like
  // an edge once they catch up; edges are ignored until they have settled
  wire settled = (settleCount == 3'h7);
  wire [3:0] next_settleCount = {1'b0, settleCount} + 4'h1;
  wire phiRise = settled & phiLevel & ~phiLast;
  wire phiFall = settled & ~phiLevel & phiLast;
  wire caFirstEdge = settled &
    (ctrlSetup[`VIB_CTL_CA1_EDGE] ? (ctrlPin[0] & ~ctrlLast[0]) : (~ctrlPin[0] & ctrlLast[0]));
  wire cbFirstEdge = settled &
    (ctrlSetup[`VIB_CTL_CB1_EDGE] ? (ctrlPin[2] & ~ctrlLast[2]) : (~ctrlPin[2] & ctrlLast[2]));
  wire caSecondEdge = settled & ctrlPin[1] & ~ctrlLast[1];
  wire cbSecondEdge = settled & ctrlPin[3] & ~ctrlLast[3];
  wire commit = phiFall & cycleOpen;
  wire [7:0] portAView = (auxSetup[`VIB_AUX_LATCH_A] & portAHeld) ? portAInLatch : portAPin;
  wire [7:0] portBRaw = (auxSetup[`VIB_AUX_LATCH_B] & portBHeld) ? portBInLatch : portBPin;
  wire [7:0] portBView = (portBDirection & portBOutLatch) | (~portBDirection & portBRaw);
  wire isTimer = (cycleIndex >= `VIB_REG_T1_COUNT_LOW) && (cycleIndex <= `VIB_REG_SHIFTER);

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  always @* begin
    if (cycleIndex == `VIB_REG_PORT_B_DATA) begin
      readMux = portBView;
    end else if (cycleIndex == `VIB_REG_PORT_A_DATA || cycleIndex == `VIB_REG_PORT_A_QUIET) begin
      readMux = portAView;
    end else if (cycleIndex == `VIB_REG_PORT_B_DIR) begin
      readMux = portBDirection;
    end else if (cycleIndex == `VIB_REG_PORT_A_DIR) begin
      readMux = portADirection;
    end else if (cycleIndex == `VIB_REG_AUX_SETUP) begin
      readMux = auxSetup;
    end else if (cycleIndex == `VIB_REG_CTRL_SETUP) begin
      readMux = ctrlSetup;
    end else if (cycleIndex == `VIB_REG_INT_FLAGS) begin
      readMux = {|(intFlags & intEnables), intFlags};
    end else if (cycleIndex == `VIB_REG_INT_ENABLES) begin
      readMux = {1'b1, intEnables};
    end else begin
      readMux = timerStorageRdData; // storage of timers and shifter lives outside
    end
  end

  // ----------------------------------------------------------------
  // bus cycle and register update
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      portBOutLatch <= `VIB_RESET_BYTE;
      portAOutLatch <= `VIB_RESET_BYTE;
      portBDirection <= `VIB_RESET_BYTE;
      portADirection <= `VIB_RESET_BYTE;
      auxSetup <= `VIB_RESET_BYTE;
      ctrlSetup <= `VIB_RESET_BYTE;
      intFlags <= 7'h00;
      intEnables <= 7'h00;
      portAInLatch <= `VIB_RESET_BYTE;
      portBInLatch <= `VIB_RESET_BYTE;
      portAHeld <= 1'b0;
      portBHeld <= 1'b0;
      phiLast <= 1'b0;
      ctrlLast <= 4'h0;
      cycleOpen <= 1'b0;
      cycleRead <= 1'b0;
      cycleIndex <= 4'h0;
      cycleData <= `VIB_RESET_BYTE;
      settleCount <= 3'h0;
      hostDataOut <= `VIB_RESET_BYTE;
      hostDataOe <= 1'b0;
      timerStorageWrData <= `VIB_RESET_BYTE;
      timerStorageWrIndex <= 4'h0;
      timerStorageWrStrobe <= 1'b0;
    end else begin
      phiLast <= phiLevel;
      ctrlLast <= ctrlPin;
      timerStorageWrStrobe <= 1'b0;
      if (!settled) begin
        settleCount <= next_settleCount[2:0];
      end
      // host cycle opens on the phase-2 rise and is sampled through the high phase
      if (phiRise & selected) begin
        cycleOpen <= 1'b1;
        cycleRead <= readCycle;
        cycleIndex <= regIndex;
      end else if (phiFall) begin
        cycleOpen <= 1'b0;
      end
      if (phiLevel & selected & cycleOpen & ~cycleRead) begin
        cycleData <= writeData;
      end
      // bus drives only in the high phase of a selected read
      hostDataOe <= phiLevel & selected & readCycle & (cycleOpen | phiRise);
      hostDataOut <= readMux;
      // input latches: an active first-line edge captures pins, a read frees them
      if (caFirstEdge) begin
        portAInLatch <= portAPin;
        portAHeld <= 1'b1;
      end else if (commit & cycleRead & (cycleIndex == `VIB_REG_PORT_A_DATA || cycleIndex == `VIB_REG_PORT_A_QUIET)) begin
        portAHeld <= 1'b0;
      end
      if (cbFirstEdge) begin
        portBInLatch <= portBPin;
        portBHeld <= 1'b1;
      end else if (commit & cycleRead & (cycleIndex == `VIB_REG_PORT_B_DATA)) begin
        portBHeld <= 1'b0;
      end
      // register writes land on the phase-2 fall
      if (commit & ~cycleRead) begin
        if (cycleIndex == `VIB_REG_PORT_B_DATA) begin
          portBOutLatch <= cycleData;
        end else if (cycleIndex == `VIB_REG_PORT_A_DATA || cycleIndex == `VIB_REG_PORT_A_QUIET) begin
          portAOutLatch <= cycleData;
        end else if (cycleIndex == `VIB_REG_PORT_B_DIR) begin
          portBDirection <= cycleData;
        end else if (cycleIndex == `VIB_REG_PORT_A_DIR) begin
          portADirection <= cycleData;
        end else if (cycleIndex == `VIB_REG_AUX_SETUP) begin
          auxSetup <= cycleData;
        end else if (cycleIndex == `VIB_REG_CTRL_SETUP) begin
          ctrlSetup <= cycleData;
        end else if (cycleIndex == `VIB_REG_INT_ENABLES) begin
          if (cycleData[`VIB_IEN_SETCLR]) begin
            intEnables <= intEnables | cycleData[6:0];
          end else begin
            intEnables <= intEnables & ~cycleData[6:0];
          end
        end else if (isTimer) begin
          timerStorageWrData <= cycleData;
          timerStorageWrIndex <= cycleIndex;
          timerStorageWrStrobe <= 1'b1;
        end
      end
      // control line flags: a new edge wins over a clear in the same cycle
      intFlags <= (intFlags & ~(commit & ~cycleRead & (cycleIndex == `VIB_REG_INT_FLAGS) ? cycleData[6:0] : 7'h00)
        & ~((commit & (cycleIndex == `VIB_REG_PORT_A_DATA)) ? 7'h03 : 7'h00)
        & ~((commit & (cycleIndex == `VIB_REG_PORT_B_DATA)) ? 7'h18 : 7'h00))
        | {2'b00, cbFirstEdge, cbSecondEdge, 1'b0, caFirstEdge, caSecondEdge};
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      portALinesOut <= `VIB_RESET_BYTE;
      portALinesOe <= `VIB_RESET_BYTE;
      portBLinesOut <= `VIB_RESET_BYTE;
      portBLinesOe <= `VIB_RESET_BYTE;
      portACtrlSecondOut <= 1'b0;
      portACtrlSecondOe <= 1'b0;
      portBCtrlFirstOut <= 1'b0;
      portBCtrlFirstOe <= 1'b0;
      portBCtrlSecondOut <= 1'b0;
      portBCtrlSecondOe <= 1'b0;
      pulseCountLevel <= 1'b0;
      serialClockLevel <= 1'b0;
      serialDataLevel <= 1'b0;
      interruptRequestOut <= 1'b0;
      interruptRequestOe <= 1'b0;
    end else begin
      portALinesOut <= portAOutLatch;
      portALinesOe <= portADirection;
      portBLinesOut <= {timerOneDrivesPin ? timerOneOutput : portBOutLatch[7], portBOutLatch[6:0]};
      portBLinesOe <= {portBDirection[7] | timerOneDrivesPin, portBDirection[6:0]};
      pulseCountLevel <= portBPin[6];
      // handshake outputs are not built here, so the control lines stay inputs
      portACtrlSecondOut <= 1'b0;
      portACtrlSecondOe <= 1'b0;
      portBCtrlFirstOut <= 1'b0;
      portBCtrlFirstOe <= 1'b0;
      portBCtrlSecondOut <= 1'b0;
      portBCtrlSecondOe <= 1'b0;
      serialClockLevel <= ctrlPin[2];
      serialDataLevel <= ctrlPin[3];
      interruptRequestOut <= 1'b0;
      interruptRequestOe <= |(intFlags & intEnables);
    end
  end
endmodule

// *** verification/vib_bus_ports_properties.sv ***
// assertions on the host bus and pin enables of vib_bus_ports
// assumes a bind to vib_bus_ports; one clock, sync reset
`timescale 1ns/1ns
module vib_bus_ports_properties (
  input wire clock,
  input wire srst,
  input wire phaseTwo,
  input wire selectActiveHigh,
  input wire selectActiveLow_n,
  input wire readNotWrite,
  input wire hostDataOe,
  input wire [7:0] portALinesOe,
  input wire [7:0] portBLinesOe,
  input wire [3:0] timerStorageWrIndex,
  input wire timerStorageWrStrobe,
  input wire interruptRequestOut,
  input wire interruptRequestOe
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  wire sel = selectActiveHigh && !selectActiveLow_n;
  // the pins cross four flops (three stages and the output), so every bound allows that slack
  sequence rdHeld; (sel && readNotWrite && phaseTwo) [*7]; endsequence
  sequence unselHeld; (!sel) [*6]; endsequence
  chk_read_drives_bus: assert property (rdHeld |-> hostDataOe)
    else $error("selected read not driving bus");
  chk_bus_off_unsel: assert property (unselHeld |-> !hostDataOe)
    else $error("bus driven while unselected");
  chk_bus_in_write: assert property ((!readNotWrite) [*6] |-> !hostDataOe)
    else $error("bus driven during write");
  chk_bus_phase_low: assert property ((!phaseTwo) [*6] |-> !hostDataOe)
    else $error("bus driven with phase low");
  chk_reset_clears: assert property (disable iff (1'b0) $fell(srst) |->
    portALinesOe == 8'h00 && portBLinesOe == 8'h00 && !interruptRequestOe)
    else $error("pins or request active after reset");
  chk_irq_open_drain: assert property (!interruptRequestOut)
    else $error("request line driven high");
  chk_dir_after_fall: assert property ($changed(portALinesOe) || $changed(portBLinesOe) |-> !$past(phaseTwo, 3))
    else $error("direction changed outside phase low");
  chk_strobe_single: assert property (timerStorageWrStrobe |=> !timerStorageWrStrobe)
    else $error("storage strobe longer than one cycle");
  chk_strobe_index: assert property (timerStorageWrStrobe |-> !phaseTwo &&
    timerStorageWrIndex >= 4'h4 && timerStorageWrIndex <= 4'hA)
    else $error("storage strobe bad index or timing");
endmodule

// *** verification/vib_periph_model.sv ***
// peripheral side: loads on the port pins and the timer storage
// assumes point to point pins with no pulls; storage answers at once
`timescale 1ns/1ns
module vib_periph_model (
  input wire clock,
  input wire [7:0] periphA,
  input wire [7:0] periphB,
  input wire [7:0] portALinesOut,
  input wire [7:0] portALinesOe,
  input wire [7:0] portBLinesOut,
  input wire [7:0] portBLinesOe,
  output wire [7:0] portALinesIn,
  output wire [7:0] portBLinesIn,
  input wire [7:0] timerStorageWrData,
  input wire [3:0] timerStorageWrIndex,
  input wire timerStorageWrStrobe,
  output wire [7:0] timerStorageRdData,
  output reg [7:0] lastData = 8'h00,
  output reg [3:0] lastIndex = 4'h0
);
  // the device driver wins where enabled, elsewhere the peripheral drives
  assign portALinesIn = (portALinesOe & portALinesOut) | (~portALinesOe & periphA);
  assign portBLinesIn = (portBLinesOe & portBLinesOut) | (~portBLinesOe & periphB);
  assign timerStorageRdData = lastData;
  always @(posedge clock) begin
    if (timerStorageWrStrobe) begin
      lastData <= timerStorageWrData;
      lastIndex <= timerStorageWrIndex;
    end
  end
endmodule

// *** verification/vib_bus_ports_bench.sv ***
// self-checking bench for vib_bus_ports: host cycles, ports, flags
// assumes the design, checker and peripheral model are compiled first
`timescale 1ns/1ns
module vib_bus_ports_bench;
  reg clock = 0, srst = 1, phaseTwo = 0, selectActiveHigh = 0, selectActiveLow_n = 1, readNotWrite = 1;
  reg [3:0] registerIndex = 4'h0;
  reg [7:0] hostDataIn = 8'h00, periphA = 8'h00, periphB = 8'h00, rd;
  reg portACtrlFirst = 0, portACtrlSecondIn = 0, portBCtrlFirstIn = 0, portBCtrlSecondIn = 0;
  reg timerOneOutput = 0, timerOneDrivesPin = 0;
  wire [7:0] hostDataOut, portALinesIn, portALinesOut, portALinesOe, portBLinesIn, portBLinesOut, portBLinesOe;
  wire [7:0] timerStorageWrData, timerStorageRdData, lastData;
  wire [3:0] timerStorageWrIndex, lastIndex;
  wire hostDataOe, portACtrlSecondOut, portACtrlSecondOe, portBCtrlFirstOut, portBCtrlFirstOe;
  wire portBCtrlSecondOut, portBCtrlSecondOe, pulseCountLevel, serialClockLevel, serialDataLevel;
  wire timerStorageWrStrobe, interruptRequestOut, interruptRequestOe;
  int miscompares = 0, n_tests = 0;
  vib_bus_ports uut (.*);
  vib_periph_model peer (.*);
  always #4 clock = ~clock;
  // ----------------------------------------
  // host cycle, compare and wrap-up tasks
  // ----------------------------------------
  task automatic cmp(input [7:0] got, input [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // s is {high select, low select}; phase high and low well over six clocks
  task automatic cyc(input [3:0] i, input rw, input [7:0] d, input [1:0] s);
    @(posedge clock) #1;
    {selectActiveHigh, selectActiveLow_n} = s;
    registerIndex = i;
    readNotWrite = rw;
    hostDataIn = d;
    repeat (2) @(posedge clock);
    #1 phaseTwo = 1;
    repeat (8) @(posedge clock);
    #1 rd = hostDataOut;
    if (rw && s == 2'b10) cmp({7'h00, hostDataOe}, 8'h01);
    phaseTwo = 0;
    repeat (2) @(posedge clock);
    #1 {selectActiveHigh, selectActiveLow_n} = 2'b01;
    readNotWrite = 1;
    repeat (8) @(posedge clock);
    #1;
  endtask
  task automatic hw(input [3:0] i, input [7:0] d);
    cyc(i, 0, d, 2'b10);
  endtask
  task automatic hr(input [3:0] i);
    cyc(i, 1, 8'h00, 2'b10);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    #1 srst = 0;
    repeat (6) @(posedge clock);
    #1 cmp(portALinesOe | portBLinesOe, 8'h00);
    cmp({2'b00, portACtrlSecondOut, portACtrlSecondOe, portBCtrlFirstOut, portBCtrlFirstOe, portBCtrlSecondOut, portBCtrlSecondOe}, 8'h00);
    for (int k = 0; k < 14; k = (k == 3) ? 11 : k + 1) begin
      hr(k[3:0]);
      cmp(rd, 8'h00);
    end
    hr(4'hE);
    cmp(rd, 8'h80);
    periphB = 8'hE5;
    hw(4'h0, 8'h3C);
    cmp(portBLinesOe, 8'h00);
    hr(4'h0);
    cmp(rd, 8'hE5);
    cmp({7'h00, pulseCountLevel}, 8'h01);
    timerOneDrivesPin = 1;
    timerOneOutput = 1;
    repeat (2) @(posedge clock);
    #1 cmp(portBLinesOe & portBLinesOut, 8'h80);
    timerOneDrivesPin = 0;
    hw(4'h2, 8'hF0);
    hw(4'h3, 8'h0F);
    hw(4'hB, 8'h01);
    hw(4'hC, 8'h01);
    hr(4'h2);
    cmp(rd, 8'hF0);
    hr(4'hC);
    cmp(rd, 8'h01);
    cmp(portBLinesOe, 8'hF0);
    cmp(portBLinesOut & portBLinesOe, 8'h30);
    hr(4'h0);
    cmp(rd, 8'h35);
    cmp({7'h00, pulseCountLevel}, 8'h00);
    hw(4'h1, 8'h96);
    hw(4'hE, 8'h82);
    periphA = 8'hC3;
    portACtrlFirst = 1;
    portBCtrlFirstIn = 1;
    portBCtrlSecondIn = 1;
    repeat (10) @(posedge clock);
    #1 cmp({7'h00, interruptRequestOe}, 8'h01);
    cmp({6'h00, serialClockLevel, serialDataLevel}, 8'h03);
    periphA = 8'h3C;
    hr(4'hF);
    cmp(rd, 8'hC6);
    hr(4'hD);
    cmp(rd, 8'h8A);
    hr(4'h1);
    cmp(rd, 8'h36);
    cmp({7'h00, interruptRequestOe}, 8'h00);
    hw(4'hF, 8'h69);
    cmp(portALinesOut & portALinesOe, 8'h09);
    cyc(4'h3, 0, 8'hFF, 2'b00);
    cyc(4'h3, 0, 8'hFF, 2'b11);
    hr(4'h3);
    cmp(rd, 8'h0F);
    hw(4'h7, 8'h5A);
    cmp(lastData, 8'h5A);
    cmp({4'h0, lastIndex}, 8'h07);
    srst = 1;
    repeat (6) @(posedge clock);
    #1 srst = 0;
    repeat (6) @(posedge clock);
    hr(4'h3);
    cmp(rd, 8'h00);
    cmp(portALinesOe, 8'h00);
    hr(4'hD);
    cmp(rd, 8'h00);
    wrap_up;
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up;
  end
endmodule
bind vib_bus_ports vib_bus_ports_properties chk (.*);
